// ---- shared/smpc_pkg.sv ----
// Purpose: Shared constants and types for the sleep-mode power controller
// Assumes: 100 MHz system clock, 8-bit I/O register space
// Notes:   Offsets are I/O offsets; data-space addresses add the window base
package smpc_pkg;

   // Clock
   localparam int CLK_PERIOD_NS = 10;

   // Register addressing
   localparam logic [5:0] IO_SC_OFS   = 6'h35;
   localparam logic [5:0] IO_SS_OFS   = 6'h34;
   localparam logic [5:0] IO_MAX_OFS  = 6'h3F;
   localparam logic [7:0] DS_IO_BASE  = 8'h20;
   localparam logic [7:0] SC_RST      = 8'h00;
   localparam logic [7:0] SS_RST      = 8'h00;

   // Field positions
   localparam int SC_ARM_BIT = 7;
   localparam int SC_SEL_MSB = 6;
   localparam int SC_SEL_LSB = 4;
   localparam int SS_DPD_BIT = 7;

   // Sleep select codes
   localparam logic [2:0] SEL_IDLE  = 3'h0;
   localparam logic [2:0] SEL_NOISE = 3'h1;
   localparam logic [2:0] SEL_PDOWN = 3'h2;
   localparam logic [2:0] SEL_PSAVE = 3'h3;
   localparam logic [2:0] SEL_STBY  = 3'h6;
   localparam logic [2:0] SEL_ESTBY = 3'h7;

   // Wake timing in cycles
   localparam logic [15:0] WAKE_STBY_CYC = 16'h0006;
   localparam logic [15:0] WAKE_HALT_CYC = 16'h0004;
   localparam logic [15:0] STARTUP_CYC   = 16'h0010;

   // Reference start-up
   localparam int VREF_START_NS = 1000;
   localparam int VREF_CYC_I    = (VREF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] VREF_CYC = 8'(VREF_CYC_I);

   typedef enum logic [2:0] {
      SM_IDLE,
      SM_NOISE,
      SM_PDOWN,
      SM_PSAVE,
      SM_STBY,
      SM_ESTBY
   } smpc_mode_e;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_WAKE
   } smpc_state_e;

endpackage

// ---- shared/smpc_wake_if.sv ----
// Purpose: Link between the controller and its wake-delay timer
// Assumes: Both ends on sys_clk_in
// Notes:   expire is combinational from the timer count
`timescale 1ns/1ps
`default_nettype none
interface smpc_wake_if;
   logic        load;
   logic [15:0] load_val;
   logic        expire;

   modport owner (output load, output load_val, input expire);
   modport timer (input load, input load_val, output expire);
endinterface
`default_nettype wire

// ---- rtl/smpc_wake_timer.sv ----
// Purpose: Down-counter that times the wake-up delay
// Assumes: load_val is at least 1
// Notes:   expire is high in the last cycle of the loaded delay
`timescale 1ns/1ps
`default_nettype none
module smpc_wake_timer
   import smpc_pkg::*;
(
   // Clock and reset
   input  wire logic   sys_clk_in,
   input  wire logic   rst_n_in,
   // Controller link
   smpc_wake_if.timer  wk
);

   typedef struct packed {
      logic [15:0] cnt;
   } smpc_tmr_s;

   smpc_tmr_s q;
   smpc_tmr_s next_q;

   always_comb
   begin
      next_q = q;
      if (wk.load)
      begin
         next_q.cnt = wk.load_val;
      end
      else if (q.cnt != 16'h0000)
      begin
         next_q.cnt = q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign wk.expire = (q.cnt == 16'h0001);

   expire_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      wk.expire && !wk.load |=> !wk.expire)
      else $error("wake timer expired twice");

endmodule
`default_nettype wire

// ---- rtl/smpc_top.sv ----
// Purpose: Sleep-mode power controller: sleep entry, clock gating, wake timing
// Assumes: CPU strobes are synchronous, one-cycle pulses
// Notes:   All outputs are registered; clock enables gate domains downstream
//
// Summary of operation
// - Select 110 with crystal clock enters Standby: Power-down but oscillator kept.
// - Standby wakes and resumes after exactly 6 clock cycles.
// - Select 111 with crystal clock enters Extended Standby: Power-save plus oscillator.
// - Extended Standby wakes and resumes after six clock cycles.
// - Standby codes are honoured only with a crystal or resonator clock.
// - Sleep instruction sleeps only while sleep_arm, bit 7, is one.
// - sleep_select bits 6:4: Idle, noise reduction, Power-down, Power-save; 100/101 reserved.
// - sleep_control sits at I/O 0x35 and data 0x55, reset 0x00.
// - I/O space is 0x00-0x3F; data space adds 0x20.
// - An enabled converter stays enabled in every sleep mode.
// - Converter turned off then on makes the next conversion extended.
// - Comparator is powered off automatically in all modes but Idle and noise reduction.
// - Comparator using the reference keeps the reference on in every sleep mode.
// - Reference on only when detector, comparator or converter need it; start-up wait.
// - Brown-out detector enabled by its fuse stays enabled in all sleep modes.
// - An enabled watchdog keeps running in all sleep modes.
// - With I/O and converter clocks stopped, input buffers off except wake pins.
// - Debug fuse, with the test port enabled, keeps the main clock running in Power-down and Power-save.
// - Disable bit written one, or debug port fuse unprogrammed, turns the test port off.
// - Test port enabled but not shifting leaves TDO undriven.
// - Power-down halts all generated clocks.
// - Power-save halts all clocks but the asynchronous timer clock.
// - Interrupt wake halts four cycles past start-up, then runs the handler.
`timescale 1ns/1ps
`default_nettype none
module smpc_top
   import smpc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // CPU register access
   input  wire logic       cpu_io_space_in,
   input  wire logic [7:0] cpu_addr_in,
   input  wire logic       cpu_wr_in,
   input  wire logic       cpu_rd_in,
   input  wire logic [7:0] cpu_wdata_in,
   output logic      [7:0] cpu_rdata_out,
   // CPU events
   input  wire logic       sleep_instr_in,
   input  wire logic       wake_in,
   output logic            cpu_run_out,
   output logic            sleeping_out,
   output logic            irq_go_out,
   // Fuses and configuration
   input  wire logic       ext_xtal_in,
   input  wire logic       onchip_debug_fuse_in,
   input  wire logic       debug_port_fuse_in,
   input  wire logic       brownout_fuse_in,
   input  wire logic       async_timer_select_in,
   // Peripheral requests
   input  wire logic       adc_enable_in,
   input  wire logic       adc_conv_start_in,
   input  wire logic       comp_enable_in,
   input  wire logic       comp_bandgap_in,
   input  wire logic       wdt_enable_in,
   input  wire logic [7:0] pin_wake_need_in,
   // Clock domain enables
   output logic            clk_cpu_en_out,
   output logic            clk_flash_en_out,
   output logic            io_clock_domain_out,
   output logic            converter_clock_domain_out,
   output logic            async_clock_domain_out,
   output logic            main_osc_en_out,
   output logic            timer_osc_en_out,
   // Analog and support blocks
   output logic            adc_power_out,
   output logic            ext_conv_out,
   output logic            comp_power_out,
   output logic            vref_en_out,
   output logic            vref_ready_out,
   output logic            bod_en_out,
   output logic            wdt_run_out,
   output logic      [7:0] input_buf_en_out,
   // Test port
   input  wire logic       tap_shift_in,
   input  wire logic       tdo_data_in,
   output logic            jtag_en_out,
   output logic            tdo_out,
   output logic            tdo_oe_out
);

   typedef struct packed {
      smpc_state_e st;
      smpc_mode_e  mode;
      logic        arm;
      logic [2:0]  sel;
      logic        dpd;
      logic [7:0]  rdata;
      logic        cpu_run;
      logic        sleeping;
      logic        irq_go;
      logic        clk_cpu;
      logic        clk_flash;
      logic        clk_io;
      logic        clk_adc;
      logic        clk_asy;
      logic        main_osc;
      logic        timer_osc;
      logic        adc_pwr;
      logic        ext_conv;
      logic        comp_pwr;
      logic        vref_en;
      logic [7:0]  vref_cnt;
      logic        vref_ready;
      logic        bod;
      logic        wdt;
      logic [7:0]  inbuf;
      logic        jtag;
      logic        tdo;
      logic        tdo_oe;
   } smpc_state_s;

   smpc_state_s q;
   smpc_state_s next_q;
   smpc_wake_if wk ();

   logic hit_sc;
   logic hit_ss;
   logic keep_osc;

   smpc_wake_timer u_wake_timer (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .wk         (wk.timer)
   );

   // Both spaces reach one register; I/O space holds only offsets up to the top
   always_comb
   begin
      hit_sc = 1'b0;
      hit_ss = 1'b0;
      if (cpu_io_space_in && cpu_addr_in <= {2'b00, IO_MAX_OFS})
      begin
         hit_sc = (cpu_addr_in[5:0] == IO_SC_OFS);
         hit_ss = (cpu_addr_in[5:0] == IO_SS_OFS);
      end
      else if (!cpu_io_space_in)
      begin
         hit_sc = (cpu_addr_in == ({2'b00, IO_SC_OFS} + DS_IO_BASE));
         hit_ss = (cpu_addr_in == ({2'b00, IO_SS_OFS} + DS_IO_BASE));
      end
   end

   always_comb
   begin
      next_q      = q;
      next_q.irq_go = 1'b0;
      wk.load     = 1'b0;
      wk.load_val = WAKE_HALT_CYC;

      // Register writes and registered read data
      if (cpu_wr_in && hit_sc)
      begin
         next_q.arm = cpu_wdata_in[SC_ARM_BIT];
         next_q.sel = cpu_wdata_in[SC_SEL_MSB:SC_SEL_LSB];
      end
      if (cpu_wr_in && hit_ss)
      begin
         next_q.dpd = cpu_wdata_in[SS_DPD_BIT];
      end
      next_q.rdata = 8'h00;
      if (cpu_rd_in && hit_sc)
      begin
         next_q.rdata[SC_ARM_BIT] = q.arm;
         next_q.rdata[SC_SEL_MSB:SC_SEL_LSB] = q.sel;
      end
      else if (cpu_rd_in && hit_ss)
      begin
         next_q.rdata[SS_DPD_BIT] = q.dpd;
      end

      next_q.jtag = debug_port_fuse_in && !next_q.dpd;
      keep_osc    = onchip_debug_fuse_in && next_q.jtag;

      case (q.st)
         ST_RUN:
         begin
            // Unarmed, reserved or unsupported codes fall through as a no-op
            if (sleep_instr_in && q.arm)
            begin
               next_q.st = ST_SLEEP;
               if (q.sel == SEL_IDLE)
                  next_q.mode = SM_IDLE;
               else if (q.sel == SEL_NOISE)
                  next_q.mode = SM_NOISE;
               else if (q.sel == SEL_PDOWN)
                  next_q.mode = SM_PDOWN;
               else if (q.sel == SEL_PSAVE)
                  next_q.mode = SM_PSAVE;
               else if (q.sel == SEL_STBY && ext_xtal_in)
                  next_q.mode = SM_STBY;
               else if (q.sel == SEL_ESTBY && ext_xtal_in)
                  next_q.mode = SM_ESTBY;
               else
                  next_q.st = ST_RUN;
            end
         end
         ST_SLEEP:
         begin
            if (wake_in)
            begin
               next_q.st = ST_WAKE;
               wk.load   = 1'b1;
               if (q.mode == SM_STBY || q.mode == SM_ESTBY)
                  wk.load_val = WAKE_STBY_CYC;
               else if (q.mode == SM_IDLE || q.mode == SM_NOISE || q.main_osc)
                  wk.load_val = WAKE_HALT_CYC;
               else
                  wk.load_val = STARTUP_CYC + WAKE_HALT_CYC;
            end
         end
         ST_WAKE:
         begin
            if (wk.expire)
            begin
               next_q.st     = ST_RUN;
               next_q.irq_go = 1'b1;
            end
         end
         default:
         begin
            next_q.st = ST_RUN;
         end
      endcase

      next_q.cpu_run   = (next_q.st == ST_RUN);
      next_q.sleeping  = (next_q.st == ST_SLEEP);
      next_q.clk_cpu   = next_q.cpu_run;
      next_q.clk_flash = next_q.cpu_run;
      next_q.clk_io    = 1'b1;
      next_q.clk_adc   = 1'b1;
      next_q.clk_asy   = 1'b1;
      next_q.main_osc  = 1'b1;
      next_q.timer_osc = async_timer_select_in;
      next_q.comp_pwr  = comp_enable_in;
      if (next_q.sleeping)
      begin
         case (next_q.mode)
            SM_IDLE:
            begin
               next_q.clk_io = 1'b1;
            end
            SM_NOISE:
            begin
               next_q.clk_io = 1'b0;
            end
            SM_PDOWN:
            begin
               next_q.clk_io    = 1'b0;
               next_q.clk_adc   = 1'b0;
               next_q.clk_asy   = 1'b0;
               next_q.timer_osc = 1'b0;
               next_q.main_osc  = keep_osc;
            end
            SM_PSAVE:
            begin
               next_q.clk_io   = 1'b0;
               next_q.clk_adc  = 1'b0;
               next_q.clk_asy  = async_timer_select_in;
               next_q.main_osc = keep_osc;
            end
            SM_STBY:
            begin
               next_q.clk_io    = 1'b0;
               next_q.clk_adc   = 1'b0;
               next_q.clk_asy   = 1'b0;
               next_q.timer_osc = 1'b0;
            end
            default:
            begin
               next_q.clk_io  = 1'b0;
               next_q.clk_adc = 1'b0;
               next_q.clk_asy = async_timer_select_in;
            end
         endcase
         if (next_q.mode != SM_IDLE && next_q.mode != SM_NOISE)
            next_q.comp_pwr = 1'b0;
      end

      // Wake pins keep their buffers so the wake condition can still be seen
      if (!next_q.clk_io && !next_q.clk_adc)
         next_q.inbuf = pin_wake_need_in;
      else
         next_q.inbuf = 8'hFF;

      // Converter power follows its enable regardless of mode; set beats clear
      next_q.adc_pwr = adc_enable_in;
      if (adc_conv_start_in)
         next_q.ext_conv = 1'b0;
      if (adc_enable_in && !q.adc_pwr)
         next_q.ext_conv = 1'b1;

      // Reference uses the comparator enable, not its sleep-gated power
      next_q.vref_en = brownout_fuse_in || (comp_enable_in && comp_bandgap_in)
                       || adc_enable_in;
      if (!next_q.vref_en)
         next_q.vref_cnt = 8'h00;
      else if (q.vref_cnt != VREF_CYC)
         next_q.vref_cnt = q.vref_cnt + 8'h01;
      next_q.vref_ready = (next_q.vref_cnt == VREF_CYC);

      next_q.bod    = brownout_fuse_in;
      next_q.wdt    = wdt_enable_in;
      next_q.tdo    = tdo_data_in;
      next_q.tdo_oe = next_q.jtag && tap_shift_in;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         q            <= '0;
         q.st         <= ST_RUN;
         q.mode       <= SM_IDLE;
         q.arm        <= SC_RST[SC_ARM_BIT];
         q.sel        <= SC_RST[SC_SEL_MSB:SC_SEL_LSB];
         q.dpd        <= SS_RST[SS_DPD_BIT];
         q.cpu_run    <= 1'b1;
         q.clk_cpu    <= 1'b1;
         q.clk_flash  <= 1'b1;
         q.clk_io     <= 1'b1;
         q.clk_adc    <= 1'b1;
         q.clk_asy    <= 1'b1;
         q.main_osc   <= 1'b1;
         q.inbuf      <= 8'hFF;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign cpu_rdata_out              = q.rdata;
   assign cpu_run_out                = q.cpu_run;
   assign sleeping_out               = q.sleeping;
   assign irq_go_out                 = q.irq_go;
   assign clk_cpu_en_out             = q.clk_cpu;
   assign clk_flash_en_out           = q.clk_flash;
   assign io_clock_domain_out        = q.clk_io;
   assign converter_clock_domain_out = q.clk_adc;
   assign async_clock_domain_out     = q.clk_asy;
   assign main_osc_en_out            = q.main_osc;
   assign timer_osc_en_out           = q.timer_osc;
   assign adc_power_out              = q.adc_pwr;
   assign ext_conv_out               = q.ext_conv;
   assign comp_power_out             = q.comp_pwr;
   assign vref_en_out                = q.vref_en;
   assign vref_ready_out             = q.vref_ready;
   assign bod_en_out                 = q.bod;
   assign wdt_run_out                = q.wdt;
   assign input_buf_en_out           = q.inbuf;
   assign jtag_en_out                = q.jtag;
   assign tdo_out                    = q.tdo;
   assign tdo_oe_out                 = q.tdo_oe;

   default clocking smpc_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   stby_wake_a: assert property (sleeping_out && q.mode == SM_STBY && wake_in
      |=> (!cpu_run_out)[*6] ##1 (cpu_run_out && irq_go_out))
      else $error("standby wake not six cycles");
   estby_wake_a: assert property (sleeping_out && q.mode == SM_ESTBY && wake_in
      |=> (!cpu_run_out)[*6] ##1 cpu_run_out)
      else $error("extended standby wake not six cycles");
   idle_wake_a: assert property (sleeping_out && q.mode == SM_IDLE && wake_in
      |=> (!cpu_run_out)[*4] ##1 (cpu_run_out && irq_go_out))
      else $error("idle wake not four cycles");
   unarmed_nop_a: assert property (cpu_run_out && sleep_instr_in && !q.arm
      |=> cpu_run_out && !sleeping_out)
      else $error("slept while unarmed");
   rsvd_nop_a: assert property (cpu_run_out && sleep_instr_in
      && (q.sel == 3'h4 || q.sel == 3'h5) |=> cpu_run_out)
      else $error("reserved code slept");
   stby_xtal_a: assert property (cpu_run_out && sleep_instr_in && q.sel[2]
      && !ext_xtal_in |=> !sleeping_out)
      else $error("standby without crystal");
   stby_osc_a: assert property (sleeping_out && q.mode == SM_STBY
      |-> main_osc_en_out && !io_clock_domain_out && !async_clock_domain_out)
      else $error("standby clocks wrong");
   pdown_clk_a: assert property (sleeping_out && q.mode == SM_PDOWN
      |-> !clk_cpu_en_out && !io_clock_domain_out && !converter_clock_domain_out
          && !async_clock_domain_out)
      else $error("power-down clock running");
   comp_off_a: assert property (sleeping_out
      && q.mode inside {SM_PDOWN, SM_PSAVE, SM_STBY, SM_ESTBY} |-> !comp_power_out)
      else $error("comparator powered in deep sleep");
   inbuf_a: assert property (##1 !io_clock_domain_out && !converter_clock_domain_out
      |-> (input_buf_en_out & ~$past(pin_wake_need_in)) == 8'h00)
      else $error("input buffer left on");
   ext_conv_a: assert property ($rose(adc_power_out) |-> ext_conv_out)
      else $error("extended conversion not flagged");
   vref_ready_a: assert property ($rose(vref_en_out)
      |-> !vref_ready_out ##1 !vref_ready_out)
      else $error("reference ready too early");
   tdo_float_a: assert property (tdo_oe_out |-> jtag_en_out && $past(tap_shift_in))
      else $error("TDO driven while idle");
   jtag_fuse_a: assert property (!$past(debug_port_fuse_in) |-> !jtag_en_out)
      else $error("test port on without fuse");

   enter_stby_c: cover property (sleeping_out && q.mode == SM_STBY);
   pdown_wake_c: cover property (sleeping_out && q.mode == SM_PDOWN && wake_in);
   rsvd_nop_c:   cover property (sleep_instr_in && q.arm && q.sel == 3'h4);
   osc_debug_c:  cover property (sleeping_out && q.mode == SM_PSAVE && main_osc_en_out);

endmodule
`default_nettype wire

// ---- verif/smpc_tb_top.sv ----
// Purpose: Self-checking bench for the sleep-mode power controller
// Assumes: Wake delays and reset values as set in smpc_pkg
// Notes:   Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module smpc_tb_top
   import smpc_pkg::*;
;
   logic       sys_clk_in, rst_n_in, cpu_io_space_in, cpu_wr_in, cpu_rd_in;
   logic [7:0] cpu_addr_in, cpu_wdata_in, cpu_rdata_out, pin_wake_need_in, input_buf_en_out;
   logic       sleep_instr_in, wake_in, cpu_run_out, sleeping_out, irq_go_out, ext_xtal_in;
   logic       onchip_debug_fuse_in, debug_port_fuse_in, brownout_fuse_in, async_timer_select_in;
   logic       adc_enable_in, adc_conv_start_in, comp_enable_in, comp_bandgap_in, wdt_enable_in;
   logic       clk_cpu_en_out, clk_flash_en_out, io_clock_domain_out, converter_clock_domain_out;
   logic       async_clock_domain_out, main_osc_en_out, timer_osc_en_out, adc_power_out;
   logic       ext_conv_out, comp_power_out, vref_en_out, vref_ready_out, bod_en_out, wdt_run_out;
   logic       tap_shift_in, tdo_data_in, jtag_en_out, tdo_out, tdo_oe_out;
   int         error_cnt, check_count;
   // Clock set per mode: cpu, flash, io, adc, async, osc, comparator, detector
   wire logic [7:0] clk_vec = {clk_cpu_en_out, clk_flash_en_out, io_clock_domain_out,
      converter_clock_domain_out, async_clock_domain_out, main_osc_en_out, comp_power_out,
      bod_en_out};
   localparam logic [7:0] CTL [6] = '{8'hA0, 8'h80, 8'h90, 8'hB0, 8'hE0, 8'hF0};
   localparam logic [7:0] VEC [6] = '{8'h01, 8'h3F, 8'h1F, 8'h09, 8'h05, 8'h0D};
   localparam int         PD_N    = int'(STARTUP_CYC + WAKE_HALT_CYC);
   localparam int         WAKE [6] = '{PD_N, 4, 4, PD_N, 6, 6};
   localparam logic [7:0] BAD [3] = '{8'h20, 8'hC0, 8'hD0};

   smpc_top dut_u (.sys_clk_in, .rst_n_in, .cpu_io_space_in, .cpu_addr_in, .cpu_wr_in,
      .cpu_rd_in, .cpu_wdata_in, .cpu_rdata_out, .sleep_instr_in, .wake_in, .cpu_run_out,
      .sleeping_out, .irq_go_out, .ext_xtal_in, .onchip_debug_fuse_in, .debug_port_fuse_in,
      .brownout_fuse_in, .async_timer_select_in, .adc_enable_in, .adc_conv_start_in,
      .comp_enable_in, .comp_bandgap_in, .wdt_enable_in, .pin_wake_need_in, .clk_cpu_en_out,
      .clk_flash_en_out, .io_clock_domain_out, .converter_clock_domain_out,
      .async_clock_domain_out, .main_osc_en_out, .timer_osc_en_out, .adc_power_out,
      .ext_conv_out, .comp_power_out, .vref_en_out, .vref_ready_out, .bod_en_out, .wdt_run_out,
      .input_buf_en_out, .tap_shift_in, .tdo_data_in, .jtag_en_out, .tdo_out, .tdo_oe_out);

   initial
   begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic step(input int n = 1);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Addresses below 0x40 go out as I/O accesses, the rest as data space
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      step();
      cpu_io_space_in = (a < 8'h40);
      cpu_addr_in = a;
      cpu_wdata_in = d;
      cpu_wr_in = w;
      cpu_rd_in = !w;
      step();
      cpu_wr_in = 1'b0;
      cpu_rd_in = 1'b0;
      if (!w)
         chk("read data", d, cpu_rdata_out);
   endtask

   task automatic nap(input logic [7:0] ctl, input logic exp);
      bus(1'b1, 8'h35, ctl);
      sleep_instr_in = 1'b1;
      step();
      sleep_instr_in = 1'b0;
      chk("run state", {6'h0, !exp, exp}, {6'h0, cpu_run_out, sleeping_out});
   endtask

   task automatic rise(input int n);
      int k;
      k = 0;
      wake_in = 1'b1;
      while (cpu_run_out !== 1'b1 && k < 40)
      begin
         step();
         wake_in = 1'b0;
         k++;
      end
      chk("wake cycles", 8'(n + 1), 8'(k));
      chk("handler start", 8'h01, {7'h0, irq_go_out});
      if (k >= 40)
         wrap_up();
   endtask

   initial
   begin
      {cpu_io_space_in, cpu_wr_in, cpu_rd_in, sleep_instr_in, wake_in} = '0;
      {adc_conv_start_in, tap_shift_in, onchip_debug_fuse_in, comp_bandgap_in} = '0;
      {ext_xtal_in, debug_port_fuse_in, brownout_fuse_in, async_timer_select_in} = '1;
      {adc_enable_in, comp_enable_in, wdt_enable_in, tdo_data_in} = '1;
      cpu_addr_in = 8'h00;
      cpu_wdata_in = 8'h00;
      pin_wake_need_in = 8'h0C;
      rst_n_in = 1'b0;
      error_cnt = 0;
      check_count = 0;
      step(5);
      rst_n_in = 1'b1;
      bus(1'b0, 8'h35, 8'h00);
      bus(1'b1, 8'h55, 8'hFF);
      bus(1'b0, 8'h35, 8'hF0);
      bus(1'b0, 8'h55, 8'hF0);
      bus(1'b0, 8'h36, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 3; i++) nap(BAD[i], 1'b0);
      ext_xtal_in = 1'b0;
      nap(8'hE0, 1'b0);
      nap(8'hF0, 1'b0);
      ext_xtal_in = 1'b1;
      chk("clock set", 8'hFF, clk_vec);
      $display("test refusals done");
      for (int i = 0; i < 6; i++)
      begin
         nap(CTL[i], 1'b1);
         chk("clock set", VEC[i], clk_vec);
         chk("input buffers", VEC[i][4] ? 8'hFF : 8'h0C, input_buf_en_out);
         chk("timer oscillator", {7'h0, VEC[i][3]}, {7'h0, timer_osc_en_out});
         chk("kept on", 8'h07, {5'h0, adc_power_out, wdt_run_out, vref_en_out});
         rise(WAKE[i]);
      end
      onchip_debug_fuse_in = 1'b1;
      nap(8'hA0, 1'b1);
      chk("clock set", 8'h05, clk_vec);
      rise(4);
      onchip_debug_fuse_in = 1'b0;
      $display("test modes done");
      {adc_enable_in, brownout_fuse_in} = 2'b00;
      step(3);
      chk("reference off", 8'h00, {7'h0, vref_en_out});
      comp_bandgap_in = 1'b1;
      step(2);
      chk("reference for comparator", 8'h01, {7'h0, vref_en_out});
      comp_bandgap_in = 1'b0;
      step(2);
      adc_enable_in = 1'b1;
      step(3);
      chk("reference wait", 8'h06, {5'h0, vref_en_out, ext_conv_out, vref_ready_out});
      adc_conv_start_in = 1'b1;
      step(int'(VREF_CYC) + 2);
      adc_conv_start_in = 1'b0;
      chk("reference ready", 8'h05, {5'h0, vref_en_out, ext_conv_out, vref_ready_out});
      $display("test analog done");
      chk("test port idle", 8'h02, {6'h0, jtag_en_out, tdo_oe_out});
      tap_shift_in = 1'b1;
      step(3);
      chk("test port shift", 8'h07, {5'h0, jtag_en_out, tdo_oe_out, tdo_out});
      tap_shift_in = 1'b0;
      debug_port_fuse_in = 1'b0;
      step(2);
      chk("fuse port off", 8'h00, {7'h0, jtag_en_out});
      debug_port_fuse_in = 1'b1;
      bus(1'b1, 8'h34, 8'h80);
      step(2);
      chk("test port off", 8'h00, {7'h0, jtag_en_out});
      $display("test port done");
      // Reset in mid-run must bring both registers back to their reset values
      rst_n_in = 1'b0;
      step(2);
      rst_n_in = 1'b1;
      bus(1'b0, 8'h35, 8'h00);
      bus(1'b0, 8'h34, 8'h00);
      chk("port after reset", 8'h01, {7'h0, jtag_en_out});
      $display("test reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
